//--- uart_consts.svh
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// =====================================================
// register offsets (own choice, plain port)
`define OFS_DATA 4'h0
`define OFS_ERR_CTRL 4'h1
`define OFS_STATUS 4'h2
`define OFS_NINTH 4'h3
`define OFS_IRQ_STAT 4'h4
`define OFS_IRQ_MASK 4'h5

// =====================================================
// field positions
`define BIT_PARITY 0
`define BIT_FRAMING 1
`define BIT_NOISE 2
`define BIT_OVERRUN 3
`define BIT_RX_FULL 4
`define BIT_TX_EMPTY 5
`define BIT_RX_NINTH 0
`define BIT_TX_NINTH 1
`define BIT_NINE_MODE 2

// =====================================================
// reset values
`define RST_DATA 8'h00
`define RST_ERR_CTRL 8'h00
`define RST_IRQ_MASK 8'h00

`endif

//--- uart_pkg.sv
package uart_pkg;
    // =====================================================
    // receive character from the shifter
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic parity_err;
        logic framing_err;
        logic noise;
    } rx_char_t;

    // character handed to the transmit shifter
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } tx_char_t;

    typedef enum logic [1:0] {
        TX_EMPTY,
        TX_LOADED
    } tx_state_t;
endpackage : uart_pkg

//--- sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag_ff
);
    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_ff <= 1'b0;
        end else if (set_pulse) begin
            flag_ff <= 1'b1;
        end else if (clr_pulse) begin
            flag_ff <= 1'b0;
        end
    end
endmodule : sticky_flag

//--- uart_error_irq_and_data_port.sv
// What this block does
// - the overrun flag raises an interrupt request when its enable is one.
// - the noise enable at bit 2 lets the noise flag request an interrupt.
// - the framing enable at bit 1 lets the framing flag request an interrupt.
// - the parity enable at bit 0 lets the parity flag request an interrupt.
// - reading the data register returns the receive buffer bits 7 to 0.
// - writing the data register loads the transmit buffer and disarms a pending receive clear.
// - data reads finish receive flag clearing and data writes transmit flag clearing.
// - the overrun enable sits at bit 3 of the error enable register.
// - in nine-bit mode a data write hands the full nine bits to the shifter.
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_error_irq_and_data_port #(
    parameter int NUM_ERR = 4,
    parameter int NUM_EV = 6
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_valid,
    input wire uart_pkg::rx_char_t rx_char,
    output logic tx_valid,
    output uart_pkg::tx_char_t tx_char,
    input wire logic tx_taken,
    output logic err_irq,
    output logic irq
);
    // =====================================================
    // elaboration checks
    // the status, irq and mask layouts are fixed at four error
    // flags plus the receive and transmit events; other sizes
    // would move fields under software's feet
    generate
        if (NUM_ERR != 4) begin : g_bad_err
            $error("error flag count must be four");
        end
        if (NUM_EV != NUM_ERR + 2) begin : g_bad_ev
            $error("event count must be the error count plus two");
        end
    endgenerate

    // =====================================================
    // write decode
    logic wr_data;
    logic wr_err_ctrl;
    logic wr_ninth;
    logic wr_irq_stat;
    logic wr_irq_mask;
    assign wr_data = reg_wr && (reg_addr == `OFS_DATA);
    assign wr_err_ctrl = reg_wr && (reg_addr == `OFS_ERR_CTRL);
    assign wr_ninth = reg_wr && (reg_addr == `OFS_NINTH);
    assign wr_irq_stat = reg_wr && (reg_addr == `OFS_IRQ_STAT);
    assign wr_irq_mask = reg_wr && (reg_addr == `OFS_IRQ_MASK);

    // =====================================================
    // read decode
    // only the data and status reads have side effects
    logic rd_data;
    logic rd_status;
    assign rd_data = reg_rd && (reg_addr == `OFS_DATA);
    assign rd_status = reg_rd && (reg_addr == `OFS_STATUS);

    // =====================================================
    // error interrupt enables
    logic [3:0] err_enable_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            err_enable_ff <= 4'(`RST_ERR_CTRL);
        end else if (wr_err_ctrl) begin
            err_enable_ff <= reg_wdata[`BIT_OVERRUN:`BIT_PARITY];
        end
    end

    // =====================================================
    // nine-bit control
    // the ninth transmit bit is kept between data writes, so a
    // fixed mark or space bit needs writing only once
    logic nine_mode_ff;
    logic tx_ninth_bit_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            nine_mode_ff <= 1'b0;
            tx_ninth_bit_ff <= 1'b0;
        end else if (wr_ninth) begin
            nine_mode_ff <= reg_wdata[`BIT_NINE_MODE];
            tx_ninth_bit_ff <= reg_wdata[`BIT_TX_NINTH];
        end
    end

    // =====================================================
    // interrupt mask
    logic [5:0] irq_mask_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_mask_ff <= 6'(`RST_IRQ_MASK);
        end else if (wr_irq_mask) begin
            irq_mask_ff <= reg_wdata[5:0];
        end
    end

    // =====================================================
    // receive buffer
    logic [7:0] rx_buf_ff;
    logic rx_ninth_bit_ff;
    logic rx_full_ff;
    logic status_seen_ff;
    logic rx_clear;
    logic accept_rx;

    // clear needs a status read first, then a data read; any data
    // access in between disarms it, so a stray write cannot clear
    // a character that software never looked at
    assign rx_clear = rd_data && status_seen_ff;
    assign accept_rx = rx_valid && !rx_full_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_seen_ff <= 1'b0;
        end else if (rd_status) begin
            status_seen_ff <= 1'b1;
        end else if (rd_data || wr_data) begin
            status_seen_ff <= 1'b0;
        end
    end

    // =====================================================
    // receive data and ninth bit
    // writes never touch this buffer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_buf_ff <= `RST_DATA;
            rx_ninth_bit_ff <= 1'b0;
        end else if (accept_rx) begin
            rx_buf_ff <= rx_char.data;
            rx_ninth_bit_ff <= rx_char.ninth;
        end
    end

    // =====================================================
    // receive full flag
    // accept_rx needs the buffer empty but rx_clear does not, so set
    // and clear can meet here, and the set wins
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_full_ff <= 1'b0;
        end else if (accept_rx) begin
            rx_full_ff <= 1'b1;
        end else if (rx_clear) begin
            rx_full_ff <= 1'b0;
        end
    end

    // =====================================================
    // error flags, cleared by the same receive sequence
    logic [3:0] err_set;
    logic [3:0] err_flag;
    assign err_set[`BIT_PARITY] = accept_rx && rx_char.parity_err;
    assign err_set[`BIT_FRAMING] = accept_rx && rx_char.framing_err;
    assign err_set[`BIT_NOISE] = accept_rx && rx_char.noise;
    // a character that meets a full buffer is lost
    assign err_set[`BIT_OVERRUN] = rx_valid && rx_full_ff;

    // =====================================================
    // error flag latches
    // one armed data read clears all four with the full flag
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_err
            sticky_flag u_flag (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .set_pulse(err_set[gi]),
                .clr_pulse(rx_clear),
                .flag_ff(err_flag[gi])
            );
        end
    endgenerate

    // =====================================================
    // error interrupt request
    // each enable gates its own flag; a disabled flag can still
    // be polled in the status register
    logic [3:0] err_req;
    assign err_req[`BIT_PARITY] =
        err_flag[`BIT_PARITY] & err_enable_ff[`BIT_PARITY];
    assign err_req[`BIT_FRAMING] =
        err_flag[`BIT_FRAMING] & err_enable_ff[`BIT_FRAMING];
    assign err_req[`BIT_NOISE] =
        err_flag[`BIT_NOISE] & err_enable_ff[`BIT_NOISE];
    assign err_req[`BIT_OVERRUN] =
        err_flag[`BIT_OVERRUN] & err_enable_ff[`BIT_OVERRUN];
    assign err_irq = |err_req;

    // =====================================================
    // transmit buffer
    uart_pkg::tx_state_t tx_state_ff;
    logic tx_empty;
    assign tx_empty = (tx_state_ff == uart_pkg::TX_EMPTY);

    // =====================================================
    // transmit data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_char <= '0;
        end else if (wr_data) begin
            tx_char.data <= reg_wdata;
            // ninth bit goes with every write, held value in nine-bit mode, zero otherwise
            tx_char.ninth <= nine_mode_ff & tx_ninth_bit_ff;
        end
    end

    // =====================================================
    // transmit buffer state
    // a data write alone completes the empty clearing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_state_ff <= uart_pkg::TX_EMPTY;
        end else begin
            case (tx_state_ff)
                uart_pkg::TX_EMPTY: begin
                    if (wr_data) begin
                        tx_state_ff <= uart_pkg::TX_LOADED;
                    end
                end
                uart_pkg::TX_LOADED: begin
                    // a write in the taking cycle is a new character,
                    // so the buffer stays loaded rather than dropping it
                    if (tx_taken && !wr_data) begin
                        tx_state_ff <= uart_pkg::TX_EMPTY;
                    end
                end
                default: begin
                    tx_state_ff <= uart_pkg::TX_EMPTY;
                end
            endcase
        end
    end
    assign tx_valid = (tx_state_ff == uart_pkg::TX_LOADED);

    // =====================================================
    // interrupt status: events latch, write one to clear
    logic [5:0] ev_set;
    logic [5:0] irq_stat;
    logic [5:0] ev_clr;
    logic tx_empty_d_ff;

    // delayed empty level for the edge detect
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_empty_d_ff <= 1'b1;
        end else begin
            tx_empty_d_ff <= tx_empty;
        end
    end

    // =====================================================
    // event pulses
    // the empty event is the rising edge of tx_empty, so the delay
    // flop resets high to avoid a false event after reset
    logic ev_tx_empty;
    logic ev_rx_char;
    assign ev_tx_empty = tx_empty && !tx_empty_d_ff;
    assign ev_rx_char = accept_rx;
    assign ev_set = {ev_tx_empty, ev_rx_char, err_set};
    assign ev_clr = wr_irq_stat ? reg_wdata[5:0] : 6'h00;

    // =====================================================
    // event latches, set wins over a write-one clear

    generate
        for (gi = 0; gi < 6; gi++) begin : g_ev
            sticky_flag u_ev (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .set_pulse(ev_set[gi]),
                .clr_pulse(ev_clr[gi]),
                .flag_ff(irq_stat[gi])
            );
        end
    endgenerate

    assign irq = |(irq_stat & irq_mask_ff);

    // =====================================================
    // read words
    logic [7:0] err_ctrl_word;
    logic [7:0] status_word;
    logic [7:0] ninth_word;
    logic [7:0] irq_stat_word;
    logic [7:0] irq_mask_word;
    assign err_ctrl_word = {4'h0, err_enable_ff};
    assign status_word = {2'b00, tx_empty, rx_full_ff, err_flag};
    assign ninth_word = {5'h00, nine_mode_ff, tx_ninth_bit_ff, rx_ninth_bit_ff};
    assign irq_stat_word = {2'b00, irq_stat};
    assign irq_mask_word = {2'b00, irq_mask_ff};

    // =====================================================
    // read mux
    // unmapped indices read as zero
    logic [7:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `OFS_DATA: nxt_rdata = rx_buf_ff;
            `OFS_ERR_CTRL: nxt_rdata = err_ctrl_word;
            `OFS_STATUS: nxt_rdata = status_word;
            `OFS_NINTH: nxt_rdata = ninth_word;
            `OFS_IRQ_STAT: nxt_rdata = irq_stat_word;
            `OFS_IRQ_MASK: nxt_rdata = irq_mask_word;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // =====================================================
    // read data register
    // zero outside the answer cycle, so a stale word never lingers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : uart_error_irq_and_data_port

//--- uart_err_props.sv
`timescale 1ns/1ps
module uart_err_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_valid,
    input wire uart_pkg::rx_char_t rx_char,
    input wire logic tx_valid,
    input wire uart_pkg::tx_char_t tx_char,
    input wire logic tx_taken,
    input wire logic err_irq,
    input wire logic irq
);
    // ==========
    // port relations
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_data_wr;
        reg_wr && reg_addr == 4'h0;
    endsequence
    sequence s_take;
        tx_valid && tx_taken && !reg_wr;
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_tx_load: assert property ((s_data_wr ##0 !tx_valid) |=>
        tx_valid && tx_char.data == $past(reg_wdata)) else $error("tx load wrong");
    chk_tx_hold: assert property (tx_valid && !tx_taken && !reg_wr |=>
        tx_valid && $stable(tx_char)) else $error("tx char moved");
    chk_tx_drop: assert property (s_take |=> !tx_valid) else $error("tx not freed");
    chk_tx_fall: assert property ($fell(tx_valid) |-> $past(tx_taken))
        else $error("tx freed early");
    chk_err_rise: assert property ($rose(err_irq) |->
        $past(rx_valid || (reg_wr && reg_addr == 4'h1))) else $error("error irq rose");
    chk_err_fall: assert property ($fell(err_irq) |->
        $past((reg_rd && reg_addr == 4'h0) || (reg_wr && reg_addr == 4'h1)))
        else $error("error irq fell");
    chk_irq_rise: assert property ($rose(irq) |->
        $past(rx_valid || (reg_wr && reg_addr == 4'h5)) || $past(tx_taken, 2))
        else $error("irq rose");
endmodule : uart_err_props

bind uart_error_irq_and_data_port uart_err_props uart_err_props_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_taken(tx_taken), .err_irq(err_irq),
    .irq(irq));

//--- serial_far_side.sv
`timescale 1ns/1ps
module serial_far_side (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic offer,
    input wire uart_pkg::rx_char_t offer_char,
    input wire logic slow,
    output logic rx_valid,
    output uart_pkg::rx_char_t rx_char,
    input wire logic tx_valid,
    input wire uart_pkg::tx_char_t tx_char,
    output logic tx_taken,
    output uart_pkg::tx_char_t seen_ff
);
    logic [2:0] wait_ff;
    // ==========
    // receive side: stale lines toggle each cycle between the inverse of the last char and the last char
    always_ff @(posedge clk_sys) begin
        rx_valid <= offer && !sys_rst;
        rx_char <= sys_rst ? '0 : (offer ? offer_char : ~rx_char);
    end
    // ==========
    // transmit side: slow mode stalls the shifter six cycles
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !tx_valid || tx_taken) begin
            wait_ff <= 3'h0;
            tx_taken <= 1'b0;
        end else if (wait_ff == (slow ? 3'h6 : 3'h0)) begin
            tx_taken <= 1'b1;
            seen_ff <= tx_char;
        end else begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
endmodule : serial_far_side

//--- tb_uart_error_irq_and_data_port.sv
`timescale 1ns/1ps
module tb_uart_error_irq_and_data_port;
    logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, offer = 1'b0;
    logic slow = 1'b0, rx_valid, tx_valid, tx_taken, err_irq, irq;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    uart_pkg::rx_char_t rx_char, offer_char = '0;
    uart_pkg::tx_char_t tx_char, seen;
    int mismatches = 0, total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    uart_error_irq_and_data_port uart_error_irq_and_data_port_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_char(rx_char),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_taken(tx_taken), .err_irq(err_irq),
        .irq(irq));
    serial_far_side serial_far_side_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .offer(offer),
        .offer_char(offer_char), .slow(slow), .rx_valid(rx_valid), .rx_char(rx_char),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_taken(tx_taken), .seen_ff(seen));
    // ==========
    // helpers
    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task chk(input string name, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {1'b0, e}, {1'b0, reg_rdata & m});
    endtask : rd
    task rx(input logic [3:0] errs, input logic [7:0] d);
        @(posedge clk_sys);
        offer <= 1'b1;
        offer_char <= {d, errs};
        @(posedge clk_sys);
        offer <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : rx
    // ==========
    // scenarios
    task t_reset();
        rd(4'h0, 8'hFF, 8'h00);
        rd(4'h1, 8'hFF, 8'h00);
        rd(4'hF, 8'hFF, 8'h00);
    endtask : t_reset
    task t_errors();
        for (int i = 0; i < 4; i++) begin
            wr(4'h1, 8'h00);
            rx(i == 3 ? 4'h0 : 4'(1 << (2 - i)), 8'(8'h30 + i));
            // a second char while full is lost and marks overrun
            if (i == 3) rx(4'h0, 8'hFF);
            #1 chk("err_irq", 9'h000, {8'h00, err_irq});
            rd(4'h2, 8'h0F, 8'(1 << i));
            wr(4'h1, 8'(1 << i));
            #1 chk("err_irq", 9'h001, {8'h00, err_irq});
            rd(4'h2, 8'h0F, 8'(1 << i));
            rd(4'h0, 8'hFF, 8'(8'h30 + i));
            #1 chk("err_irq", 9'h000, {8'h00, err_irq});
            chk("irq", 9'h000, {8'h00, irq});
        end
    endtask : t_errors
    task t_tx();
        slow <= 1'b1;
        wr(4'h3, 8'h06);
        wr(4'h0, 8'hA5);
        rd(4'h2, 8'h20, 8'h00);
        rd(4'h3, 8'h01, 8'h00);
        rd(4'h0, 8'hFF, 8'h33);
        for (int n = 0; n < 20 && tx_valid; n++) @(posedge clk_sys);
        #1 chk("tx_char", {8'hA5, 1'b1}, seen);
        rd(4'h2, 8'h20, 8'h20);
        chk("irq", 9'h000, {8'h00, irq});
        wr(4'h5, 8'h20);
        #1 chk("irq", 9'h001, {8'h00, irq});
        wr(4'h4, 8'h20);
        #1 chk("irq", 9'h000, {8'h00, irq});
    endtask : t_tx
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_errors();
        t_tx();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
endmodule : tb_uart_error_irq_and_data_port
